// ### dv/info_rom_write_control_tb_top.sv
`timescale 1ns/10ps
module info_rom_write_control_tb_top;
    localparam int INFO_CYC = 8;
    localparam int TO1 = 40;
    localparam int TO2 = 60;
    localparam int TO3 = 80;
    logic                  i_mclk = 1'b0;
    logic                  i_sys_rst = 1'b1;
    logic                  mode = 1'b0;
    logic                  hang = 1'b0;
    logic [7:0]            dly = 8'h00;
    irw_pkg::irw_cpu_req_t cpu = '0;
    irw_pkg::irw_sfr_req_t sfr = '0;
    irw_pkg::irw_arr_req_t arr;
    logic [7:0]            cpu_rdata, sfr_rdata, rd_addr, arr_rdata;
    logic                  cpu_rvalid, stall, abort, done, rd, rd_eep;
    logic                  wdt_en, flash_en, two, perm, eep_busy;
    int                    mismatches = 0;
    int                    checks = 0;
    int                    aborts = 0;

    always #2.5 i_mclk = ~i_mclk;
    always @(posedge i_mclk) if (abort === 1'b1) aborts <= aborts + 1;

    irw_info_rom_ctrl #(.INFO_WR_CYC(INFO_CYC), .TO1_CYC(TO1),
        .TO2_CYC(TO2), .TO3_CYC(TO3)) u_dut (
        .i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_cpu(cpu),
        .o_cpu_rdata(cpu_rdata), .o_cpu_rvalid(cpu_rvalid),
        .o_cpu_stall(stall), .i_sfr(sfr), .o_sfr_rdata(sfr_rdata),
        .o_arr(arr), .o_arr_abort(abort), .i_arr_done(done),
        .o_arr_rd(rd), .o_arr_rd_eep(rd_eep), .o_arr_rd_addr(rd_addr),
        .i_arr_rdata(arr_rdata), .i_fast_slow_mode(mode),
        .o_wdt_rst_en(wdt_en), .o_flash_wr_en(flash_en),
        .o_flash_two_byte(two), .o_global_perm(perm),
        .o_eep_busy(eep_busy));

    irw_nvm_model u_nvm (.i_mclk(i_mclk), .i_arr(arr), .i_abort(abort),
        .o_done(done), .i_rd(rd), .i_rd_eep(rd_eep), .i_rd_addr(rd_addr),
        .o_rdata(arr_rdata), .i_dly(dly), .i_hang(hang));

    task automatic chk(input string nm, input logic [23:0] e,
                       input logic [23:0] g);
        checks++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic finish_test;
        if (mismatches == 0 && checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // Requests are raised after an edge and dropped after the taking edge
    task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_mclk) #1 sfr = '{1'b1, 1'b0, a, d};
        @(posedge i_mclk) #1 sfr.wr = 1'b0;
    endtask

    task automatic sfr_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge i_mclk) #1 sfr = '{1'b0, 1'b1, a, 8'h00};
        @(posedge i_mclk) #1 sfr.rd = 1'b0;
        d = sfr_rdata;
    endtask

    task automatic cpu_wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge i_mclk) #1 cpu = '{1'b1, 1'b0, a, d};
        @(posedge i_mclk) #1 cpu.wr = 1'b0;
    endtask

    task automatic cpu_rd(input logic [15:0] a, output logic [7:0] d,
                          output logic v);
        @(posedge i_mclk) #1 cpu = '{1'b0, 1'b1, a, 8'h00};
        @(posedge i_mclk) #1 cpu.rd = 1'b0;
        d = cpu_rdata;
        v = cpu_rvalid;
    endtask

    // Counts busy cycles, giving up at the bound
    task automatic wait_free(input int lim, output int n);
        n = 0;
        while ((stall === 1'b1 || eep_busy === 1'b1) && n < lim) begin
            @(posedge i_mclk) #1 n++;
        end
    endtask

    function automatic logic [7:0] key_exp(input logic [7:0] k);
        if (k == irw_pkg::K_FLASH1 || k == irw_pkg::K_FLASH2) return 8'h80;
        if (k == irw_pkg::K_INFO) return 8'h10;
        if (k == irw_pkg::K_EEP) return 8'h20;
        return 8'h00;
    endfunction

    function automatic int to_cyc(input logic [1:0] s);
        return (s == 2'b01) ? TO1 : (s == 2'b10) ? TO2 : TO3;
    endfunction

    initial begin
        #200000;
        mismatches++;
        finish_test();
    end

    initial begin
        logic [7:0]  d, e, top_v, k;
        logic [15:0] a;
        logic [1:0]  s;
        logic        v, ep;
        int          n;
        void'($urandom(50));
        repeat (5) @(posedge i_mclk);
        #1 i_sys_rst = 1'b0;
        sfr_rd(irw_pkg::WREN_OFS, d); chk("c9_rst", 8'h00, d);
        sfr_rd(irw_pkg::AUX_OFS, d); chk("f7_rst", 8'h06, d);
        sfr_rd(irw_pkg::CMD_OFS, d); chk("perm_rst", 0, d[0]);
        sfr_wr(8'h55, 8'hff);
        sfr_rd(8'h55, d); chk("unmapped", 8'h00, d);
        // Every write-enable key, a random byte and zero
        for (int i = 0; i < 6; i++) begin
            k = (i == 0) ? 8'h47 : (i == 1) ? 8'h74 : (i == 2) ? 8'ha1 :
                (i == 3) ? 8'he2 : (i == 4) ? 8'($urandom) : 8'h00;
            sfr_wr(irw_pkg::WREN_OFS, k);
            sfr_rd(irw_pkg::WREN_OFS, d);
            chk("c9_key", key_exp(k), d);
            chk("flash_en", key_exp(k) == 8'h80, flash_en);
            chk("two_byte", k == 8'h74, two);
        end
        for (int i = 0; i < 2; i++) begin
            sfr_wr(irw_pkg::CMD_OFS, i ? 8'h56 : 8'h65);
            sfr_rd(irw_pkg::CMD_OFS, d);
            chk("perm_rd", !i, d[0]);
            chk("perm_out", !i, perm);
        end
        for (int c = 0; c < 8; c++) begin
            sfr_wr(irw_pkg::AUX_OFS, {2'(c >> 1), 6'h06});
            mode = c[0];
            #1 chk("wdt_en", c[2] & (c[1] | c[0]), wdt_en);
        end
        sfr_rd(irw_pkg::AUX_OFS, d); chk("f7_rw", 8'hc6, d);
        // no interrupts pend, no code stored
        // watchdog reset off before any array write
        sfr_wr(irw_pkg::AUX_OFS, 8'h06);
        for (int i = 0; i < 8; i++) begin
            ep = i >= 4;
            a = ep ? irw_pkg::EEP_BASE : irw_pkg::INFO_BASE;
            a = a + ((i % 4 == 0) ? 16'h0000 :
                (i % 4 == 1) ? (ep ? 16'h00ff : 16'h003f) :
                16'($urandom_range(62, 1)));
            e = 8'($urandom);
            dly = 8'($urandom_range(20));
            if (i == 1) top_v = e;
            sfr_wr(irw_pkg::CMD_OFS, irw_pkg::K_PERM);
            sfr_wr(irw_pkg::WREN_OFS, ep ? irw_pkg::K_EEP : irw_pkg::K_INFO);
            cpu_wr(a, e);
            chk("stall_on", !ep, stall);
            chk("busy_on", ep, eep_busy);
            wait_free(200, n);
            if (ep) chk("eep_len", 1, n >= dly + 1 && n <= dly + 4);
            else chk("info_len", 1, n >= INFO_CYC - 1 &&
                     n <= INFO_CYC + dly + 4);
            sfr_wr(irw_pkg::WREN_OFS, 8'h00);
            cpu_rd(a, d, v); chk("rd_data", e, d);
            chk("rd_valid", 1, v);
            chk("rd_stall", 0, stall);
        end
        cpu_rd(16'he540, d, v); chk("rd_out_hi", 0, v);
        cpu_rd(16'hedff, d, v); chk("rd_out_lo", 0, v);
        // Stores to the info window lacking one of the two enables
        for (int i = 0; i < 2; i++) begin
            sfr_wr(irw_pkg::CMD_OFS, i ? irw_pkg::K_PERM : 8'h00);
            sfr_wr(irw_pkg::WREN_OFS, i ? irw_pkg::K_EEP : irw_pkg::K_INFO);
            cpu_wr(irw_pkg::INFO_TOP, ~top_v);
            chk("no_stall", 0, stall);
            chk("no_busy", 0, eep_busy);
            repeat (30) @(posedge i_mclk);
            cpu_rd(irw_pkg::INFO_TOP, d, v); chk("no_write", top_v, d);
        end
        // Stuck array: every time-out code, then EEPROM, then none
        hang = 1'b1;
        for (int j = 0; j < 5; j++) begin
            s = (j == 3) ? 2'b01 : (j == 4) ? 2'b00 : 2'(j + 1);
            ep = j == 3;
            n = aborts;
            sfr_wr(irw_pkg::AUX_OFS, {5'h00, s, 1'b0});
            sfr_wr(irw_pkg::CMD_OFS, irw_pkg::K_PERM);
            sfr_wr(irw_pkg::WREN_OFS, ep ? irw_pkg::K_EEP : irw_pkg::K_INFO);
            cpu_wr(ep ? irw_pkg::EEP_BASE : irw_pkg::INFO_BASE, 8'h3c);
            k = 8'(n);
            wait_free(120, n);
            if (j == 4) begin
                chk("no_timeout", 1, stall);
                hang = 1'b0;
                wait_free(20, n);
                chk("late_done", 0, stall);
                chk("no_abort", 24'(k), 24'(aborts));
            end else begin
                chk("to_len", 1, n >= to_cyc(s) - 3 &&
                    n <= to_cyc(s) + 1);
                sfr_rd(irw_pkg::WREN_OFS, d);
                // Pulse counted after its edge
                chk("abort_cnt", 24'(k) + 1, 24'(aborts));
                chk("to_flag", ep ? 8'h28 : 8'h50, d);
                sfr_wr(irw_pkg::WREN_OFS, ep ? irw_pkg::K_INFO : 8'h00);
                sfr_rd(irw_pkg::WREN_OFS, d);
                chk("to_clear", ep ? 8'h10 : 8'h00, d);
            end
        end
        finish_test();
    end
endmodule // info_rom_write_control_tb_top

// ### dv/irw_nvm_model.sv
`timescale 1ns/10ps
module irw_nvm_model (
    // Clock
    input  logic                  i_mclk,
    // Write side
    input  irw_pkg::irw_arr_req_t i_arr,
    input  logic                  i_abort,
    output logic                  o_done,
    // Read side
    input  logic                  i_rd,
    input  logic                  i_rd_eep,
    input  logic [7:0]            i_rd_addr,
    output logic [7:0]            o_rdata,
    // Bench knobs: completion delay and a stuck array
    input  logic [7:0]            i_dly,
    input  logic                  i_hang
);
    logic [7:0] info_mem [64];
    logic [7:0] eep_mem  [256];
    logic       pend     = 1'b0;
    logic       pend_eep;
    logic [7:0] pend_adr;
    logic [7:0] pend_dat;
    logic [7:0] cnt      = 8'h00;
    logic [7:0] last     = 8'h00;

    initial begin
        foreach (eep_mem[k]) eep_mem[k] = 8'hff;
        foreach (info_mem[k]) info_mem[k] = 8'hff;
    end

    // variable completion time, or none at all while stuck
    always @(posedge i_mclk) begin
        o_done <= 1'b0;
        if (i_arr.wr) begin
            pend     <= 1'b1;
            pend_eep <= i_arr.eep;
            pend_adr <= i_arr.addr;
            pend_dat <= i_arr.wdata;
            cnt      <= i_dly;
        end else if (i_abort) begin
            pend <= 1'b0; // Abandoned write leaves the cell alone
        end else if (pend && cnt != 8'h00) begin
            cnt <= cnt - 8'h01;
        end else if (pend && !i_hang) begin
            pend   <= 1'b0;
            o_done <= 1'b1;
            if (pend_eep) eep_mem[pend_adr] <= pend_dat;
            else info_mem[pend_adr[5:0]] <= pend_dat;
        end
    end

    // bytes answer at once; idle bus shows the inverse of the last
    always_comb begin
        if (!i_rd) o_rdata = ~last;
        else if (i_rd_eep) o_rdata = eep_mem[i_rd_addr];
        else o_rdata = info_mem[i_rd_addr[5:0]];
    end

    always @(posedge i_mclk) if (i_rd) last <= o_rdata;
endmodule // irw_nvm_model

// ### hdl/irw_busy_timer.sv
`timescale 1ns/10ps
module irw_busy_timer #(
    parameter int unsigned MIN_CYC = irw_pkg::INFO_WR_CYC,
    parameter int unsigned TO1_CYC = irw_pkg::TO1_CYC,
    parameter int unsigned TO2_CYC = irw_pkg::TO2_CYC,
    parameter int unsigned TO3_CYC = irw_pkg::TO3_CYC
) (
    // Clock and reset
    input  logic       i_mclk,
    input  logic       i_sys_rst,
    // Control
    input  logic       i_start,
    input  logic       i_info,
    input  logic [1:0] i_sel,
    input  logic       i_arr_done,
    // Status pulses
    output logic       o_done,
    output logic       o_timeout
);

    irw_pkg::irw_tmr_st_t q, d;
    logic [23:0]          lim;
    logic                 seen;
    logic                 min_ok;

    // Last counter value for a time-out selection
    function automatic logic [23:0] last_cyc(input logic [1:0] sel);
        unique case (sel)
            2'b01:   return 24'(TO1_CYC - 1);
            2'b10:   return 24'(TO2_CYC - 1);
            default: return 24'(TO3_CYC - 1);
        endcase
    endfunction

    // Completion is taken from the array; info writes also wait out a fixed floor
    always_comb begin
        lim    = last_cyc(q.sel);
        seen   = q.seen | i_arr_done;
        // RQ3 info busy floor
        min_ok = !q.info || (q.cnt >= 24'(MIN_CYC - 1));
        // RQ17 done from array
        o_done = q.run && seen && min_ok;
        // RQ14 selected time-out
        o_timeout = q.run && !o_done && (q.sel != 2'b00) && (q.cnt == lim);
        d = q;
        if (i_start) begin
            d.run  = 1'b1;
            d.info = i_info;
            d.seen = 1'b0;
            d.sel  = i_sel;
            d.cnt  = '0;
        end else if (o_done || o_timeout) begin
            d.run  = 1'b0;
            d.seen = 1'b0;
        end else if (q.run) begin
            d.cnt  = q.cnt + 24'h1;
            d.seen = seen;
        end
    end

    // State register
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    a_timeout_never_off: assert property ( // RQ14
        (q.sel == 2'b00) |-> !o_timeout)
        else $error("Time-out raised while disabled");

    a_info_floor_held: assert property ( // RQ3
        (o_done && q.info) |-> (q.cnt >= 24'(MIN_CYC - 1)))
        else $error("Info write ended before its busy time");

endmodule // irw_busy_timer

// ### hdl/irw_info_rom_ctrl.sv
`timescale 1ns/10ps

// Overview of operation
// RQ1 - Info memory holds 64 bytes at data addresses E500h to E53Fh.
// RQ2 - A data-space store inside the info window starts an info write.
// RQ3 - An info write stays busy for a programmable time near 0.6 ms.
// RQ4 - The CPU stalls during an info write; peripherals keep running.
// RQ5 - Software services interrupts that pended while the CPU stalled.
// RQ6 - Software turns the watchdog reset off before an info write.
// RQ7 - Info reads are data-space loads answered without extra wait.
// RQ8 - Key 47h or 74h sets flash enable; 74h allows two bytes.
// RQ9 - Key A1h sets info enable; any other value clears it.
// RQ10 - Key E2h sets EEPROM enable; any other value clears it.
// RQ11 - Time-out flag at bit 6 set on time-out, cleared when info enable low.
// RQ12 - Bit 4 of the enable register reads the info enable flag.
// RQ13 - Watchdog reset: 0x off, 10 in run modes only, 11 always.
// RQ14 - Time-out select: 00 off, else 6.9, 27 or 55 ms then abandon.
// RQ15 - The device holds 256 bytes of data EEPROM.
// RQ16 - EEPROM bytes sit at EE00h to EEFFh, each readable and writable.
// RQ17 - EEPROM writes end on the array done indication or time-out.
// RQ18 - A built-in time-out frees a write that never finishes.
// RQ19 - Software reads back each EEPROM byte to verify it.
// RQ20 - In-system reprogramming keeps a boot region untouched by software.
// RQ21 - Key 65h to the command register sets global access permission.
// RQ22 - Info stores without both enables change nothing and never stall.
module irw_info_rom_ctrl #(
    parameter int unsigned INFO_WR_CYC = irw_pkg::INFO_WR_CYC,
    parameter int unsigned TO1_CYC     = irw_pkg::TO1_CYC,
    parameter int unsigned TO2_CYC     = irw_pkg::TO2_CYC,
    parameter int unsigned TO3_CYC     = irw_pkg::TO3_CYC
) (
    // Clock and reset
    input  logic                   i_mclk,
    input  logic                   i_sys_rst,

    // CPU data-space port
    input  irw_pkg::irw_cpu_req_t  i_cpu,
    output logic [7:0]             o_cpu_rdata,
    output logic                   o_cpu_rvalid,
    output logic                   o_cpu_stall,

    // Special-function register port
    input  irw_pkg::irw_sfr_req_t  i_sfr,
    output logic [7:0]             o_sfr_rdata,

    // Nonvolatile array write side
    output irw_pkg::irw_arr_req_t  o_arr,
    output logic                   o_arr_abort,
    input  logic                   i_arr_done,

    // Nonvolatile array read side
    output logic                   o_arr_rd,
    output logic                   o_arr_rd_eep,
    output logic [7:0]             o_arr_rd_addr,
    input  logic [7:0]             i_arr_rdata,

    // System status and control
    input  logic                   i_fast_slow_mode,
    output logic                   o_wdt_rst_en,
    output logic                   o_flash_wr_en,
    output logic                   o_flash_two_byte,
    output logic                   o_global_perm,
    output logic                   o_eep_busy
);

    irw_pkg::irw_ctrl_st_t q, d;

    // Decoded access windows and events
    logic       hit_info;
    logic       hit_eep;

    logic       take_info;
    logic       take_eep;

    logic       tmr_done;
    logic       tmr_to;

    logic [7:0] wren_view;
    logic [1:0] tsel;

    // Address decode of the CPU request
    always_comb begin
        // RQ1 info window
        hit_info = irw_pkg::in_win(i_cpu.addr, irw_pkg::INFO_BASE,
                                   irw_pkg::INFO_TOP);

        // RQ16 EEPROM window
        hit_eep  = irw_pkg::in_win(i_cpu.addr, irw_pkg::EEP_BASE,
                                   irw_pkg::EEP_TOP);
    end

    // Store acceptance; a store arriving while the array is busy is not taken
    always_comb begin
        // RQ2 store starts write
        // RQ22 both enables needed
        take_info = i_cpu.wr && hit_info && q.info && q.perm &&
                    (q.fsm == irw_pkg::ST_IDLE);

        // EEPROM stores need no permission, no stall
        // RQ16 EEPROM byte write
        take_eep  = i_cpu.wr && hit_eep && q.eep &&
                    (q.fsm == irw_pkg::ST_IDLE);
    end

    assign tsel = q.aux[irw_pkg::TSEL_HI:irw_pkg::TSEL_LO];

    // Busy period and write time-out share one counter
    irw_busy_timer #(
        .MIN_CYC (INFO_WR_CYC),
        .TO1_CYC (TO1_CYC),
        .TO2_CYC (TO2_CYC),
        .TO3_CYC (TO3_CYC)
    ) u_timer (
        .i_mclk     (i_mclk),
        .i_sys_rst  (i_sys_rst),
        .i_start    (take_info || take_eep),
        .i_info     (take_info),
        .i_sel      (tsel),
        .i_arr_done (i_arr_done),
        .o_done     (tmr_done),
        .o_timeout  (tmr_to)
    );

    // Read view of the write-enable register
    always_comb begin
        wren_view                      = 8'h00;
        wren_view[irw_pkg::FLASH_BIT]  = q.flash;
        wren_view[irw_pkg::TO_BIT]     = q.to;
        wren_view[irw_pkg::EEP_BIT]    = q.eep;

        // RQ12 info enable readback
        wren_view[irw_pkg::INFO_BIT]   = q.info;
        wren_view[irw_pkg::EEPTO_BIT]  = q.eepto;
    end

    // Next-state logic for registers, flags and the write sequencer
    always_comb begin
        d        = q;
        d.arr.wr = 1'b0;
        d.abort  = 1'b0;
        d.rvalid = 1'b0;

        // Register writes; a key only takes effect as a whole byte
        if (i_sfr.wr && (i_sfr.addr == irw_pkg::WREN_OFS)) begin
            // RQ8 flash keys
            d.flash = (i_sfr.wdata == irw_pkg::K_FLASH1) ||
                      (i_sfr.wdata == irw_pkg::K_FLASH2);
            d.two   = (i_sfr.wdata == irw_pkg::K_FLASH2);
            // RQ9 info key
            d.info  = (i_sfr.wdata == irw_pkg::K_INFO);
            // RQ10 EEPROM key
            d.eep   = (i_sfr.wdata == irw_pkg::K_EEP);
        end

        if (i_sfr.wr && (i_sfr.addr == irw_pkg::CMD_OFS)) begin
            // RQ21 permission key
            d.perm = (i_sfr.wdata == irw_pkg::K_PERM);
        end

        if (i_sfr.wr && (i_sfr.addr == irw_pkg::AUX_OFS)) begin
            d.aux = i_sfr.wdata;
        end

        // Register reads answer one cycle later; holes read zero
        if (i_sfr.rd) begin
            unique case (i_sfr.addr)
                irw_pkg::WREN_OFS: d.sfr_rdata = wren_view;
                irw_pkg::AUX_OFS:  d.sfr_rdata = q.aux;
                irw_pkg::CMD_OFS:  d.sfr_rdata = {7'h00, q.perm};
                default:           d.sfr_rdata = 8'h00;
            endcase
        end

        // RQ11 set wins over clear
        d.to    = (tmr_to && (q.fsm == irw_pkg::ST_INFO)) ||
                  (q.to && q.info);

        // EEPROM time-out follows its enable
        d.eepto = (tmr_to && (q.fsm == irw_pkg::ST_EEP)) ||
                  (q.eepto && q.eep);

        // Write sequencer
        unique case (q.fsm)
            irw_pkg::ST_IDLE: begin
                if (take_info || take_eep) begin
                    // RQ15 byte-wide array address
                    d.arr.wr    = 1'b1;
                    d.arr.eep   = take_eep;
                    d.arr.addr  = i_cpu.addr[7:0];
                    d.arr.wdata = i_cpu.wdata;
                    // RQ4 stall on info only
                    d.fsm = take_info ? irw_pkg::ST_INFO : irw_pkg::ST_EEP;
                end
            end

            irw_pkg::ST_INFO, irw_pkg::ST_EEP: begin
                // RQ18 escape stuck write
                if (tmr_done || tmr_to) begin
                    d.fsm   = irw_pkg::ST_IDLE;
                    d.abort = tmr_to;
                end
            end

            // Illegal codes go back to idle
            default: begin
                d.fsm = irw_pkg::ST_IDLE;
            end
        endcase

        // RQ7 loads need no wait
        if (o_arr_rd) begin
            d.rdata  = i_arr_rdata;
            d.rvalid = 1'b1;
        end
    end

    // State register; reset gives idle, flags clear, aux at default
    always_ff @(posedge i_mclk or posedge i_sys_rst) begin
        if (i_sys_rst) begin
            q     <= '0;
            q.fsm <= irw_pkg::ST_IDLE;
            q.aux <= irw_pkg::AUX_RST;
        end else begin
            q <= d;
        end
    end

    // Array read strobe is combinational so the byte returns next edge
    always_comb begin
        o_arr_rd      = i_cpu.rd && (hit_info || hit_eep);
        o_arr_rd_eep  = hit_eep;
        o_arr_rd_addr = i_cpu.addr[7:0];
    end

    // Outputs from the state register
    assign o_cpu_rdata      = q.rdata;
    assign o_cpu_rvalid     = q.rvalid;
    assign o_sfr_rdata      = q.sfr_rdata;

    assign o_arr            = q.arr;
    assign o_arr_abort      = q.abort;

    // Enable levels
    assign o_flash_wr_en    = q.flash;
    assign o_flash_two_byte = q.two;
    assign o_global_perm    = q.perm;
    // Peripherals are never gated here, only the CPU is held
    assign o_cpu_stall      = (q.fsm == irw_pkg::ST_INFO);
    assign o_eep_busy       = (q.fsm == irw_pkg::ST_EEP);

    // RQ13 watchdog reset modes
    assign o_wdt_rst_en = q.aux[irw_pkg::WDT_HI] &&
                          (q.aux[irw_pkg::WDT_LO] || i_fast_slow_mode);

    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_sys_rst);

    // Accepted info store followed by a held stall
    sequence s_info_store;
        i_cpu.wr && hit_info && q.info && q.perm &&
        (q.fsm == irw_pkg::ST_IDLE);
    endsequence

    sequence s_stall_held;
        o_cpu_stall && o_arr.wr && !o_arr.eep ##1 o_cpu_stall;
    endsequence

    a_info_stall_on: assert property ( // RQ4
        s_info_store |=> s_stall_held)
        else $error("Info store did not stall the CPU");

    a_gated_no_stall: assert property ( // RQ22
        (i_cpu.wr && hit_info && !(q.info && q.perm) &&
         (q.fsm == irw_pkg::ST_IDLE))
        |=> (!o_cpu_stall && !o_arr.wr))
        else $error("Gated info store reached the array");

    a_info_key_read: assert property ( // RQ9
        (i_sfr.wr && (i_sfr.addr == irw_pkg::WREN_OFS) &&
         (i_sfr.wdata == irw_pkg::K_INFO))
        ##[1:2] (i_sfr.rd && (i_sfr.addr == irw_pkg::WREN_OFS))
        |=> o_sfr_rdata[irw_pkg::INFO_BIT])
        else $error("Info enable not read back after key");

    a_flash_key_two: assert property ( // RQ8
        (i_sfr.wr && (i_sfr.addr == irw_pkg::WREN_OFS))
        |=> (o_flash_wr_en == ($past(i_sfr.wdata) == irw_pkg::K_FLASH1 ||
                               $past(i_sfr.wdata) == irw_pkg::K_FLASH2)) &&
            (o_flash_two_byte == ($past(i_sfr.wdata) == irw_pkg::K_FLASH2)))
        else $error("Flash enable key decoded wrongly");

    a_eep_key_set: assert property ( // RQ10
        (i_sfr.wr && (i_sfr.addr == irw_pkg::WREN_OFS))
        |=> (q.eep == ($past(i_sfr.wdata) == irw_pkg::K_EEP)))
        else $error("EEPROM enable key decoded wrongly");

    a_perm_key_set: assert property ( // RQ21
        (i_sfr.wr && (i_sfr.addr == irw_pkg::CMD_OFS))
        |=> (o_global_perm == ($past(i_sfr.wdata) == irw_pkg::K_PERM)))
        else $error("Permission key decoded wrongly");

    a_timeout_clears: assert property ( // RQ11
        (!q.info && !(tmr_to && (q.fsm == irw_pkg::ST_INFO)))
        |=> !q.to)
        else $error("Time-out flag held with info enable low");

    a_read_no_wait: assert property ( // RQ7
        (i_cpu.rd && hit_info) |=> (o_cpu_rvalid &&
                                     o_cpu_rdata == $past(i_arr_rdata)))
        else $error("Info read not answered on the next edge");

    a_wdt_run_only: assert property ( // RQ13
        (q.aux[irw_pkg::WDT_HI:irw_pkg::WDT_LO] == 2'b10)
        |-> (o_wdt_rst_en == i_fast_slow_mode))
        else $error("Watchdog reset enable wrong for code 10");

    a_eep_waits_done: assert property ( // RQ17
        (o_eep_busy && !tmr_done && !tmr_to) |=> o_eep_busy)
        else $error("EEPROM write ended without done or time-out");

    a_abort_on_to: assert property ( // RQ18
        (tmr_to && (o_cpu_stall || o_eep_busy))
        |=> (o_arr_abort && !o_cpu_stall && !o_eep_busy))
        else $error("Stuck write not abandoned on time-out");

endmodule // irw_info_rom_ctrl

// ### hdl/irw_pkg.sv
package irw_pkg;

    // Register offsets in the special-function space
    localparam logic [7:0] WREN_OFS = 8'hc9;
    localparam logic [7:0] AUX_OFS  = 8'hf7;
    localparam logic [7:0] CMD_OFS  = 8'h97;

    // Key values written to the control registers
    localparam logic [7:0] K_FLASH1 = 8'h47;
    localparam logic [7:0] K_FLASH2 = 8'h74;
    localparam logic [7:0] K_INFO   = 8'ha1;
    localparam logic [7:0] K_EEP    = 8'he2;
    localparam logic [7:0] K_PERM   = 8'h65;

    // Values after reset
    localparam logic [7:0] AUX_RST  = 8'h06;

    // Field positions
    localparam int FLASH_BIT = 7;
    localparam int TO_BIT    = 6;
    localparam int EEP_BIT   = 5;
    localparam int INFO_BIT  = 4;
    localparam int EEPTO_BIT = 3;
    localparam int WDT_HI    = 7;
    localparam int WDT_LO    = 6;
    localparam int TSEL_HI   = 2;
    localparam int TSEL_LO   = 1;
    localparam int PERM_BIT  = 0;

    // Data-space windows
    localparam int          INFO_WORDS = 64;
    localparam int          EEP_BYTES  = 256;
    localparam logic [15:0] INFO_BASE  = 16'he500;
    localparam logic [15:0] INFO_TOP   = INFO_BASE + 16'(INFO_WORDS - 1);
    localparam logic [15:0] EEP_BASE   = 16'hee00;
    localparam logic [15:0] EEP_TOP    = EEP_BASE + 16'(EEP_BYTES - 1);

    // Times as printed, and their cycle counts
    localparam real CLK_NS     = 5.0;
    localparam real INFO_WR_MS = 0.6;
    localparam real TO1_MS     = 6.9;
    localparam real TO2_MS     = 27.0;
    localparam real TO3_MS     = 55.0;
    localparam int  INFO_WR_CYC = int'(INFO_WR_MS * 1.0e6 / CLK_NS);
    localparam int  TO1_CYC     = int'(TO1_MS * 1.0e6 / CLK_NS);
    localparam int  TO2_CYC     = int'(TO2_MS * 1.0e6 / CLK_NS);
    localparam int  TO3_CYC     = int'(TO3_MS * 1.0e6 / CLK_NS);

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_INFO = 3'b010,
        ST_EEP  = 3'b100
    } irw_fsm_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } irw_cpu_req_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } irw_sfr_req_t;

    typedef struct packed {
        logic       wr;
        logic       eep;
        logic [7:0] addr;
        logic [7:0] wdata;
    } irw_arr_req_t;

    typedef struct packed {
        logic        run;
        logic        info;
        logic        seen;
        logic [1:0]  sel;
        logic [23:0] cnt;
    } irw_tmr_st_t;

    typedef struct packed {
        irw_fsm_t     fsm;
        logic         flash;
        logic         two;
        logic         info;
        logic         eep;
        logic         to;
        logic         eepto;
        logic         perm;
        logic [7:0]   aux;
        logic [7:0]   rdata;
        logic         rvalid;
        logic [7:0]   sfr_rdata;
        logic         abort;
        irw_arr_req_t arr;
    } irw_ctrl_st_t;

    // Inclusive address window test
    function automatic logic in_win(input logic [15:0] a,
                                    input logic [15:0] lo,
                                    input logic [15:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction

endpackage
